/* File: src/prw_reset_ctrl.sv */
// Added by the designer: the address-and-strobe port.
module prw_reset_ctrl #(
    parameter int NP = prw_pkg::NUM_PERIPH
) (
    input  wire logic          i_clk_sys,
    input  wire logic          i_rstn,
    input  wire logic [7:0]    i_addr,
    input  wire logic [31:0]   i_wdata,
    input  wire logic          i_wr,
    input  wire logic          i_rd,
    output logic      [31:0]   o_rdata,
    input  wire logic          i_wdog_fire,
    input  wire logic [NP-1:0] i_periph_done,
    output logic      [NP-1:0] o_periph_reset
);

    ////////////////////////////////////////////////////////////////////////////////
    // state

    logic [NP-1:0] ctrl_ff;       // software reset-control bits
    logic [NP-1:0] nxt_ctrl;
    logic [NP-1:0] wdsel_ff;      // watchdog select bits
    logic [NP-1:0] nxt_wdsel;
    logic [NP-1:0] wdrst_ff;      // one-cycle watchdog reset pulse
    logic [NP-1:0] nxt_wdrst;
    logic [NP-1:0] done_ff;       // completion status
    logic [NP-1:0] nxt_done;
    logic [31:0]   rdata_ff;      // registered read data
    logic [31:0]   nxt_rdata;
    logic [NP-1:0] done_sync;     // synchronised peripheral done
    logic [NP-1:0] reset_now;     // reset request being driven

    // zero-extend a peripheral vector to a bus word, upper bits reserved
    function automatic logic [31:0] widen(input logic [NP-1:0] v);
        widen = {{(32-NP){1'b0}}, v};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // done inputs come from other reset domains, so synchronise

    prw_sync2 #(
        .WIDTH (NP)
    ) u_done_sync (
        .i_clk_sys (i_clk_sys),
        .i_rstn    (i_rstn),
        .i_async   (i_periph_done),
        .o_sync    (done_sync)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // next-state logic

    always_comb
    begin
        nxt_ctrl  = ctrl_ff;
        nxt_wdsel = wdsel_ff;
        nxt_rdata = 32'h0000_0000;
        // register writes
        if (i_wr && i_addr == prw_pkg::CTRL_OFS)
        begin
            nxt_ctrl = i_wdata[NP-1:0];
        end
        if (i_wr && i_addr == prw_pkg::WDSEL_OFS)
        begin
            nxt_wdsel = i_wdata[NP-1:0];
        end
        // done register ignores writes
        // register reads; unmapped reads return zero
        if (i_rd)
        begin
            unique case (i_addr)
                prw_pkg::CTRL_OFS:  nxt_rdata = widen(ctrl_ff);
                prw_pkg::WDSEL_OFS: nxt_rdata = widen(wdsel_ff);
                prw_pkg::DONE_OFS:  nxt_rdata = widen(done_ff);
                default:            nxt_rdata = 32'h0000_0000;
            endcase
        end
        // watchdog pulses only the selected bits
        nxt_wdrst = i_wdog_fire ? wdsel_ff : '0;
        // done follows the peripheral, forced low while held
        nxt_done  = done_sync & ~reset_now;
    end

    // reset to a peripheral: control bit or watchdog pulse
    assign reset_now = ctrl_ff | wdrst_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // registers

    // control resets to all ones, keeping everything in reset
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            ctrl_ff  <= prw_pkg::CTRL_RESET_VAL[NP-1:0];
            wdsel_ff <= prw_pkg::WDSEL_RESET_VAL[NP-1:0];
            wdrst_ff <= '0;
            done_ff  <= prw_pkg::DONE_RESET_VAL[NP-1:0];
            rdata_ff <= 32'h0000_0000;
        end
        else
        begin
            ctrl_ff  <= nxt_ctrl;
            wdsel_ff <= nxt_wdsel;
            wdrst_ff <= nxt_wdrst;
            done_ff  <= nxt_done;
            rdata_ff <= nxt_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs; reset drives from flops, no glitch path from the bus

    assign o_periph_reset = reset_now;
    assign o_rdata        = rdata_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    a_wdog_selected: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        i_wdog_fire |=> ((o_periph_reset & $past(wdsel_ff)) == $past(wdsel_ff)))
        else $error("selected peripheral not reset on watchdog fire");

    a_wdog_unselected: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        i_wdog_fire |=> ((o_periph_reset & ~$past(wdsel_ff)) == ($past(ctrl_ff) & ~$past(wdsel_ff))))
        else $error("unselected peripheral affected by watchdog");

    // a select write must land whole at the strobe edge
    a_wdsel_write: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (i_wr && i_addr == prw_pkg::WDSEL_OFS) |=> (wdsel_ff == $past(i_wdata[NP-1:0])))
        else $error("select write not stored");

    a_wdsel_readback: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (i_rd && i_addr == prw_pkg::WDSEL_OFS) |=> (o_rdata == widen($past(wdsel_ff))))
        else $error("select readback mismatch");

    // per bit: a released peripheral's done tracks its synchronised input
    // checked every cycle, so a partial release is covered as well
    a_done_follows: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        1'b1 |=> ((done_ff & ~$past(reset_now)) == ($past(done_sync) & ~$past(reset_now))))
        else $error("done does not follow peripheral");

    a_done_reserved: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (i_rd && i_addr == prw_pkg::DONE_OFS) |=> (o_rdata[31:NP] == '0 && o_rdata[NP-1:0] == $past(done_ff)))
        else $error("done readback wrong");

    a_ctrl_holds: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (i_wr && i_addr == prw_pkg::CTRL_OFS) |=> ((o_periph_reset & $past(i_wdata[NP-1:0])) == $past(i_wdata[NP-1:0])))
        else $error("control write did not hold reset");

    a_done_cleared: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        ((done_ff & $past(reset_now)) == '0))
        else $error("done set while peripheral held");

    a_unmapped_zero: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (i_rd && i_addr > prw_pkg::DONE_OFS) |=> (o_rdata == 32'h0000_0000))
        else $error("unmapped read not zero");

    // without a read strobe the data bus rests at zero
    // a stale word here would let software see an old status
    a_rdata_idle: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        !i_rd |=> (o_rdata == 32'h0000_0000))
        else $error("read data not idle");

    // a control write with no watchdog pulse sets the reset pattern exactly
    // this covers both holding and releasing, not only holding
    a_ctrl_release: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (i_wr && i_addr == prw_pkg::CTRL_OFS && !i_wdog_fire)
        |=> (o_periph_reset == $past(i_wdata[NP-1:0])))
        else $error("control write not applied");

    // after release the whole vector is still held until software acts
    a_power_up_held: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        ($past(ctrl_ff) == '1 && !$past(i_wr)) |-> (o_periph_reset == '1))
        else $error("peripheral left reset without a write");

endmodule

/* File: pkg/prw_pkg.sv */
package prw_pkg;

    // register offsets
    localparam logic [7:0]  CTRL_OFS        = 8'h00;
    localparam logic [7:0]  WDSEL_OFS       = 8'h04;
    localparam logic [7:0]  DONE_OFS        = 8'h08;
    // peripheral count, field occupies bits 24:0
    localparam int          NUM_PERIPH      = 25;
    // reset values
    localparam logic [24:0] CTRL_RESET_VAL  = 25'h1ffffff;
    localparam logic [24:0] WDSEL_RESET_VAL = 25'h0000000;
    localparam logic [24:0] DONE_RESET_VAL  = 25'h0000000;
    // bit positions of the peripherals
    localparam int          BIT_ADC              = 0;
    localparam int          BIT_BUS_CONTROL      = 1;
    localparam int          BIT_DMA              = 2;
    localparam int          BIT_I2C_PORT_0       = 3;
    localparam int          BIT_I2C_PORT_1       = 4;
    localparam int          BIT_USER_PIN_CONTROL = 5;
    localparam int          BIT_QSPI_PIN_CONTROL = 6;
    localparam int          BIT_DEBUG_PORT       = 7;
    localparam int          BIT_USER_PAD_CONTROL = 8;
    localparam int          BIT_QSPI_PAD_CONTROL = 9;
    localparam int          BIT_PROG_IO_0        = 10;
    localparam int          BIT_PROG_IO_1        = 11;
    localparam int          BIT_PLL_SYSTEM       = 12;
    localparam int          BIT_PLL_USB          = 13;
    localparam int          BIT_PWM              = 14;
    localparam int          BIT_RTC              = 15;
    localparam int          BIT_SPI_PORT_0       = 16;
    localparam int          BIT_SPI_PORT_1       = 17;
    localparam int          BIT_SYSTEM_CONFIG    = 18;
    localparam int          BIT_SYSTEM_INFO      = 19;
    localparam int          BIT_TESTBENCH_MGR    = 20;
    localparam int          BIT_TIMER            = 21;
    localparam int          BIT_SERIAL_PORT_0    = 22;
    localparam int          BIT_SERIAL_PORT_1    = 23;
    localparam int          BIT_USB_CONTROLLER   = 24;

endpackage

/* File: src/prw_sync2.sv */
// two-stage synchroniser for a vector of asynchronous levels
module prw_sync2 #(
    parameter int WIDTH = 25
) (
    input  wire logic             i_clk_sys,
    input  wire logic             i_rstn,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] meta_ff;    // first stage, read only by second
    logic [WIDTH-1:0] sync_ff;    // second stage

    // plain shift, the first stage feeds nothing else
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            meta_ff <= '0;
            sync_ff <= '0;
        end
        else
        begin
            meta_ff <= i_async;
            sync_ff <= meta_ff;
        end
    end

    assign o_sync = sync_ff;

endmodule

/* File: test/prw_periph_model.sv */
// far-side peripherals: done returns a cycle or two after release
module prw_periph_model (
    input  wire logic        i_clk_sys,
    input  wire logic        i_slow,
    input  wire logic [24:0] i_reset,
    output logic      [24:0] o_done
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [24:0] st1_ff;  // first stage of internal init
    logic [24:0] st2_ff;  // slow path adds one stage
    // init sequence restarts whenever reset is seen
    always_ff @(posedge i_clk_sys)
    begin
        st1_ff <= ~i_reset;
        st2_ff <= st1_ff & ~i_reset;
    end
    // done drops at once under reset, no stale level
    assign o_done = (i_slow ? st2_ff : st1_ff) & ~i_reset;
endmodule

/* File: test/prw_reset_ctrl_test.sv */
module prw_reset_ctrl_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_clk_sys = 1'b0;
    logic        i_rstn = 1'b0;
    logic [7:0]  i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h0;
    logic        i_wr = 1'b0;
    logic        i_rd = 1'b0;
    logic        i_wdog_fire = 1'b0;
    logic        slow = 1'b0;      // partner speed
    logic [31:0] o_rdata;
    logic [24:0] done;
    logic [24:0] o_periph_reset;
    int          failures = 0;
    int          tests_run = 0;
    int          cycles = 0;
    int          seed = 32'hb8ae77fb;
    int          ctrl_m;           // model of control register
    int          wdsel_m;          // model of select register
    logic [31:0] got;
    prw_reset_ctrl dut (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_wdog_fire(i_wdog_fire), .i_periph_done(done), .o_periph_reset(o_periph_reset));
    prw_periph_model far (.i_clk_sys(i_clk_sys), .i_slow(slow), .i_reset(o_periph_reset),
        .o_done(done));
    ////////////////////////////////////////////////////////////////////////////////
    // clock and hang guard, ceiling well above the expected run
    initial forever #2 i_clk_sys = ~i_clk_sys;
    always @(posedge i_clk_sys)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            failures++;
            end_of_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] val);
        tests_run++;
        if (val !== exp)
        begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, exp, val);
        end
    endtask
    // one-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk_sys);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
    endtask
    // data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_clk_sys);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask
    task automatic end_of_test();
        $display("counts: %0d checks, %0d mismatches", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (4) @(posedge i_clk_sys);
        i_rstn <= 1'b1;
        chk("held", 32'h1ffffff, {7'h0, o_periph_reset});
        rd(8'h00, got); chk("ctrl", 32'h1ffffff, got);
        rd(8'h04, got); chk("wdsel", 32'h0, got);
        rd(8'h08, got); chk("done", 32'h0, got);
        $display("reset values done");
        // one peripheral released per pass, random select set
        for (int i = 0; i < 25; i++)
        begin
            slow <= i[0];
            ctrl_m = ~(1 << i) & 32'h1ffffff;
            wdsel_m = $random(seed);
            wr(8'h04, wdsel_m);
            wr(8'h08, 32'hffffffff);
            wr(8'h00, ctrl_m);
            rd(8'h04, got); chk("wdsel", wdsel_m & 32'h1ffffff, got);
            // software waits for done before use; clear stale readback first
            got = 32'h0;
            for (int k = 0; k < 20 && got !== (1 << i); k++) rd(8'h08, got);
            chk("done", 1 << i, got);
            rd(8'h10, got); chk("unmapped", 32'h0, got);
            chk("reset", ctrl_m, {7'h0, o_periph_reset});
            @(posedge i_clk_sys);
            i_wdog_fire <= 1'b1;
            @(posedge i_clk_sys);
            i_wdog_fire <= 1'b0;
            #1 chk("fired", ctrl_m | wdsel_m & 32'h1ffffff, {7'h0, o_periph_reset});
            @(posedge i_clk_sys);
            #1 chk("after", ctrl_m, {7'h0, o_periph_reset});
            got = 32'h0;
            for (int k = 0; k < 20 && got !== (1 << i); k++) rd(8'h08, got);
            chk("redone", 1 << i, got);
        end
        $display("per-peripheral passes done");
        wr(8'h00, 32'hffffffff);
        repeat (3) @(posedge i_clk_sys);
        rd(8'h08, got); chk("done held", 32'h0, got);
        $display("re-hold done");
        end_of_test();
    end
endmodule
